/* common/lsfc_pkg.sv */
// Constants and state type for the segment display frame controller
package lsfc_pkg;
	// Register addresses on the special function register bus
	localparam logic [7:0] ADDR_DISP_CFG = 8'h95;
	localparam logic [7:0] ADDR_CLK_DIV = 8'h96;
	localparam logic [7:0] ADDR_VOLT_CFG = 8'h9C;
	localparam logic [7:0] ADDR_SEG_PTR = 8'hAC;
	localparam logic [7:0] ADDR_SEG_DAT = 8'hAE;
	localparam logic [7:0] ADDR_UPD_CTL = 8'hB1;
	// Reset values
	localparam logic [7:0] RST_DISP_CFG = 8'h00;
	localparam logic [7:0] RST_CLK_DIV = 8'h00;
	localparam logic [7:0] RST_VOLT_CFG = 8'h00;
	localparam logic [7:0] RST_SEG_PTR = 8'h00;
	localparam logic [7:0] RST_SEG_DAT = 8'h00;
	localparam logic [7:0] RST_UPD_CTL = 8'h00;
	// display_configuration fields
	localparam int CFG_ENABLE_BIT = 7;
	localparam int CFG_MEM_CLEAR_BIT = 6;
	localparam int CFG_BLINK_EN_BIT = 5;
	localparam int CFG_PSM_OFF_BIT = 4;
	localparam int CFG_CLK_SEL_BIT = 3;
	localparam int CFG_BIAS_BIT = 2;
	localparam int CFG_MUX_LSB = 0;
	// display_clock_divider fields
	localparam int DIV_FD_LSB = 0;
	localparam int DIV_RATE_LSB = 4;
	localparam int DIV_MODE_LSB = 6;
	// drive_voltage_configuration fields
	localparam int VOLT_LEVEL_LSB = 0;
	localparam int VOLT_LADDER_BIT = 6;
	// segment_memory_pointer fields and update control freeze bit
	localparam int PTR_WRITE_BIT = 7;
	localparam int PTR_ADDR_LSB = 0;
	localparam logic [7:0] PTR_WRITABLE_MASK = 8'hBF;
	localparam int UPD_FREEZE_BIT = 0;
	// Segment memory geometry
	localparam int SEG_BYTES = 15;
	localparam logic [5:0] SEG_LAST_ADDR = 6'h0E;
	localparam int SEG_LINES = 29;
	// Display clock and slow clock ratio (2048 Hz / 128 Hz)
	localparam int DCLK_FAST_HZ = 2048;
	localparam int DCLK_SLOW_HZ = 128;
	localparam logic [3:0] SLOW_PRESCALE = 4'(DCLK_FAST_HZ / DCLK_SLOW_HZ - 1);
	localparam logic [3:0] SLOW_FD_MAX = 4'h3;
	// Automatic blink half periods in fast display clock ticks
	localparam logic [13:0] BLINK_HALF_0 = 14'h0200;
	localparam logic [13:0] BLINK_HALF_1 = 14'h0400;
	localparam logic [13:0] BLINK_HALF_2 = 14'h0800;
	localparam logic [13:0] BLINK_HALF_3 = 14'h1000;
	localparam logic [13:0] BLINK_HALF_4 = 14'h2000;
	// Blink mode encodings
	localparam logic [1:0] BLINK_SW_OFF = 2'h0;
	localparam logic [1:0] BLINK_SW_ON = 2'h1;
	localparam logic [1:0] BLINK_AUTO = 2'h2;
	localparam logic [1:0] BLINK_AUTO_SLOW = 2'h3;

	typedef struct packed {
		logic [7:0] cfg_reg;
		logic [7:0] div_reg;
		logic [7:0] volt_reg;
		logic [7:0] ptr_reg;
		logic [7:0] dat_reg;
		logic [7:0] upd_reg;
		logic [SEG_BYTES-1:0][7:0] work_reg;
		logic [SEG_BYTES-1:0][7:0] shown_reg;
		logic [1:0] sync_reg;
		logic dclk_prev_reg;
		logic [3:0] pre_reg;
		logic [3:0] frame_cnt_reg;
		logic phase_reg;
		logic [1:0] com_reg;
		logic [13:0] blink_cnt_reg;
		logic blink_on_reg;
	} lsfc_state_t;

	typedef struct packed {
		logic [3:0] com_active;
		logic invert;
		logic display_on;
		logic [SEG_LINES-1:0] seg_on;
	} lsfc_drive_t;
endpackage

/* hdl/lsfc_top.sv */
// Segment display frame controller: registers, segment memory and waveform timing
// Operation
// - Frame and common switching rates come from display clock, mux level, divider field.
// - Fast clock gives sixteen frame rates; slow clock reaches a reduced subset.
// - Drive waveform inverts at twice the common switching rate for zero DC.
// - Blink enable bit puts display into alternating on/off blink mode.
// - Software blink follows blink mode field; software toggles it at its rate.
// - Automatic blink only with real time clock on; five rates from two fields.
// - Fifteen segment memory bytes at addresses 0 to 14, two lines each at addresses 0 to 13.
// - Low nibble even line, high nibble odd line; address 14 holds line 28.
// - Segment memory is kept through deepest power saving mode.
// - Pointer write selects a byte and launches a read or write at once.
// - Pointer write with top bit set copies data register into memory.
// - Pointer write with top bit clear loads data register from memory.
// - While freeze bit set display keeps frozen contents unless memory clear blanks them; clearing freeze shows new ones.
// - Ladder select bit picks charge pump when clear, external ladder when set.
// - Charge pump with display disabled switches voltage generation off.
// - Six bit bias level field gives 64 drive levels for the charge pump.
// - Clock select bit chooses 2048 Hz or 128 Hz display clock.
// - Memory clear bit or power on reset zeroes every segment byte.
// - Pointer holds write flag bit 7, reserved bit 6, address bits 5 to 0.
module lsfc_top
	import lsfc_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// Special function register bus
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_WR,
	input wire logic [7:0] SFR_WDATA,
	output logic [7:0] SFR_RDATA,
	// System status
	input wire logic DCLK_IN,
	input wire logic RTC_ENABLE,
	input wire logic DEEP_POWER_SAVING_MODE,
	// Glass drive
	output lsfc_drive_t DRIVE,
	// Voltage generation
	output logic PUMP_ENABLE,
	output logic LADDER_SELECT,
	output logic BIAS_HALF,
	output logic [5:0] BIAS_LEVEL
);

	lsfc_state_t s_reg;
	lsfc_state_t s_next;

	////////////////////////////////////////////////////////////////////////////////
	// Decoded controls

	logic [1:0] mux_sel;
	logic [1:0] com_last;
	logic [3:0] fd_sel;
	logic [3:0] fd_eff;
	logic [1:0] blink_mode;
	logic [1:0] blink_rate;
	logic [13:0] blink_half;
	logic [5:0] ptr_addr;
	logic addr_ok;
	logic freeze;
	logic dclk_rise;
	logic slow_tick;
	logic frame_tick;
	logic half_done;
	logic blink_tick;
	logic auto_blink;
	logic display_active;

	assign mux_sel = s_reg.cfg_reg[CFG_MUX_LSB +: 2];
	assign com_last = (mux_sel == 2'h0) ? 2'h0 : mux_sel;
	assign fd_sel = s_reg.div_reg[DIV_FD_LSB +: 4];
	assign blink_rate = s_reg.div_reg[DIV_RATE_LSB +: 2];
	assign blink_mode = s_reg.div_reg[DIV_MODE_LSB +: 2];
	assign ptr_addr = SFR_WDATA[PTR_ADDR_LSB +: 6];
	assign addr_ok = (ptr_addr <= SEG_LAST_ADDR);
	assign freeze = s_reg.upd_reg[UPD_FREEZE_BIT];

	// Only the second synchroniser flop feeds the edge detector
	assign dclk_rise = s_reg.sync_reg[1] & ~s_reg.dclk_prev_reg;
	assign slow_tick = dclk_rise && (s_reg.pre_reg == SLOW_PRESCALE);

	// Slow clock caps the divider, so only a subset of rates is reachable
	always_comb begin
		if (s_reg.cfg_reg[CFG_CLK_SEL_BIT]) begin
			frame_tick = slow_tick;
			fd_eff = (fd_sel > SLOW_FD_MAX) ? SLOW_FD_MAX : fd_sel;
		end else begin
			frame_tick = dclk_rise;
			fd_eff = fd_sel;
		end
	end

	assign half_done = frame_tick && (s_reg.frame_cnt_reg == fd_eff);

	always_comb begin
		case ({blink_mode[0], blink_rate})
			3'b000: blink_half = BLINK_HALF_0;
			3'b001: blink_half = BLINK_HALF_1;
			3'b010: blink_half = BLINK_HALF_2;
			3'b011: blink_half = BLINK_HALF_3;
			default: blink_half = BLINK_HALF_4;
		endcase
	end

	assign auto_blink = (blink_mode == BLINK_AUTO) || (blink_mode == BLINK_AUTO_SLOW);
	assign blink_tick = dclk_rise && (s_reg.blink_cnt_reg >= blink_half - 14'h0001);

	// Display visible: enabled, not forced off in deep power saving, blink phase on
	always_comb begin
		display_active = s_reg.cfg_reg[CFG_ENABLE_BIT];
		if (DEEP_POWER_SAVING_MODE && s_reg.cfg_reg[CFG_PSM_OFF_BIT]) begin
			display_active = 1'b0;
		end
		if (s_reg.cfg_reg[CFG_BLINK_EN_BIT]) begin
			if (auto_blink) begin
				// Without the real time clock automatic blink holds the display on
				if (RTC_ENABLE && !s_reg.blink_on_reg) begin
					display_active = 1'b0;
				end
			end else if (blink_mode == BLINK_SW_OFF) begin
				display_active = 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write decode: at most one strobe per cycle

	logic wr_cfg;
	logic wr_div;
	logic wr_volt;
	logic wr_ptr;
	logic wr_dat;
	logic wr_upd;
	logic mem_clear;

	always_comb begin
		wr_cfg = 1'b0;
		wr_div = 1'b0;
		wr_volt = 1'b0;
		wr_ptr = 1'b0;
		wr_dat = 1'b0;
		wr_upd = 1'b0;
		if (SFR_WR) begin
			if (SFR_ADDR == ADDR_DISP_CFG) begin
				wr_cfg = 1'b1;
			end else if (SFR_ADDR == ADDR_CLK_DIV) begin
				wr_div = 1'b1;
			end else if (SFR_ADDR == ADDR_VOLT_CFG) begin
				wr_volt = 1'b1;
			end else if (SFR_ADDR == ADDR_SEG_PTR) begin
				wr_ptr = 1'b1;
			end else if (SFR_ADDR == ADDR_SEG_DAT) begin
				wr_dat = 1'b1;
			end else if (SFR_ADDR == ADDR_UPD_CTL) begin
				wr_upd = 1'b1;
			end
		end
	end

	// Strobe that zeroes both memory copies
	assign mem_clear = wr_cfg && SFR_WDATA[CFG_MEM_CLEAR_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		s_next = s_reg;
		s_next.sync_reg = {s_reg.sync_reg[0], DCLK_IN};
		s_next.dclk_prev_reg = s_reg.sync_reg[1];

		if (dclk_rise) begin
			s_next.pre_reg = s_reg.pre_reg + 4'h1;
		end

		// Half slot counter, inversion phase and active common
		if (frame_tick) begin
			if (half_done) begin
				s_next.frame_cnt_reg = 4'h0;
				s_next.phase_reg = ~s_reg.phase_reg;
				if (s_reg.phase_reg) begin
					s_next.com_reg = (s_reg.com_reg >= com_last) ? 2'h0 : s_reg.com_reg + 2'h1;
				end
			end else begin
				s_next.frame_cnt_reg = s_reg.frame_cnt_reg + 4'h1;
			end
		end
		if (s_reg.com_reg > com_last) begin
			s_next.com_reg = 2'h0;
		end

		// Automatic blink counter runs only with the real time clock
		if (!(RTC_ENABLE && auto_blink && s_reg.cfg_reg[CFG_BLINK_EN_BIT])) begin
			s_next.blink_cnt_reg = 14'h0000;
			s_next.blink_on_reg = 1'b1;
		end else if (blink_tick) begin
			s_next.blink_cnt_reg = 14'h0000;
			s_next.blink_on_reg = ~s_reg.blink_on_reg;
		end else if (dclk_rise) begin
			s_next.blink_cnt_reg = s_reg.blink_cnt_reg + 14'h0001;
		end

		// Memory clear is a one-shot action and never reads back set
		s_next.cfg_reg[CFG_MEM_CLEAR_BIT] = 1'b0;

		// Register writes from the decoded strobes
		if (wr_cfg) begin
			s_next.cfg_reg = SFR_WDATA;
			s_next.cfg_reg[CFG_MEM_CLEAR_BIT] = 1'b0;
		end
		if (wr_div) begin
			s_next.div_reg = SFR_WDATA;
		end
		if (wr_volt) begin
			s_next.volt_reg = SFR_WDATA;
		end
		if (wr_ptr) begin
			s_next.ptr_reg = SFR_WDATA & PTR_WRITABLE_MASK;
			if (SFR_WDATA[PTR_WRITE_BIT]) begin
				if (addr_ok) begin
					s_next.work_reg[ptr_addr[3:0]] = s_reg.dat_reg;
				end
			end else begin
				s_next.dat_reg = addr_ok ? s_reg.work_reg[ptr_addr[3:0]] : 8'h00;
			end
		end
		if (wr_dat) begin
			s_next.dat_reg = SFR_WDATA;
		end
		if (wr_upd) begin
			s_next.upd_reg = SFR_WDATA;
		end

		// Clear takes both copies so a frozen display also blanks
		if (mem_clear) begin
			s_next.work_reg = '0;
			s_next.shown_reg = '0;
		end else if (!freeze) begin
			s_next.shown_reg = s_next.work_reg;
		end
	end

	// Memory is never cleared by power saving mode, only by reset or clear
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			s_reg <= '0;
			s_reg.cfg_reg <= RST_DISP_CFG;
			s_reg.div_reg <= RST_CLK_DIV;
			s_reg.volt_reg <= RST_VOLT_CFG;
			s_reg.ptr_reg <= RST_SEG_PTR;
			s_reg.dat_reg <= RST_SEG_DAT;
			s_reg.upd_reg <= RST_UPD_CTL;
			s_reg.blink_on_reg <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data

	always_comb begin
		if (SFR_ADDR == ADDR_DISP_CFG) begin
			SFR_RDATA = s_reg.cfg_reg;
		end else if (SFR_ADDR == ADDR_CLK_DIV) begin
			SFR_RDATA = s_reg.div_reg;
		end else if (SFR_ADDR == ADDR_VOLT_CFG) begin
			SFR_RDATA = s_reg.volt_reg;
		end else if (SFR_ADDR == ADDR_SEG_PTR) begin
			SFR_RDATA = s_reg.ptr_reg;
		end else if (SFR_ADDR == ADDR_SEG_DAT) begin
			SFR_RDATA = s_reg.dat_reg;
		end else if (SFR_ADDR == ADDR_UPD_CTL) begin
			SFR_RDATA = s_reg.upd_reg;
		end else begin
			SFR_RDATA = 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Glass drive: one segment line per generate entry

	logic [SEG_LINES-1:0] seg_bits;
	logic [3:0] com_bits;

	for (genvar line = 0; line < SEG_LINES; line++) begin : g_seg
		logic [7:0] seg_byte;
		assign seg_byte = s_reg.shown_reg[line / 2];
		// Even line in low nibble, odd in high nibble, bit index is the common
		assign seg_bits[line] = seg_byte[(line % 2) * 4 + int'(s_reg.com_reg)];
	end

	always_comb begin
		com_bits = 4'h0;
		com_bits[s_reg.com_reg] = 1'b1;
	end

	// One process drives the whole port struct, so no field has two drivers
	always_comb begin
		DRIVE = '0;
		if (display_active) begin
			DRIVE.com_active = com_bits;
			DRIVE.seg_on = seg_bits;
		end
		DRIVE.invert = s_reg.phase_reg;
		DRIVE.display_on = display_active;
	end

	assign LADDER_SELECT = s_reg.volt_reg[VOLT_LADDER_BIT];
	assign PUMP_ENABLE = !s_reg.volt_reg[VOLT_LADDER_BIT] && display_active;
	assign BIAS_LEVEL = s_reg.volt_reg[VOLT_LEVEL_LSB +: 6];
	assign BIAS_HALF = s_reg.cfg_reg[CFG_BIAS_BIT];

endmodule // lsfc_top

/* tb/lsfc_glass.sv */
// Passive glass model watching common rotation and inversion
module lsfc_glass
	import lsfc_pkg::*;
(
	// Clock and control
	input wire logic clk,
	input wire logic clr,
	// Drive from the controller
	input wire lsfc_drive_t drive,
	// Observations
	output logic [3:0] seen,
	output int bad
);
	logic [3:0] com_q = 4'h0;
	logic inv_q = 1'b0;
	logic armed = 1'b0;
	int flips = 0;
	initial seen = 4'h0;
	initial bad = 0;
	////////////////////////////////////////
	// First rotation after clr only arms: the slot was entered mid-way
	always @(posedge clk) begin
		com_q <= drive.com_active;
		inv_q <= drive.invert;
		seen <= clr ? 4'h0 : seen | drive.com_active;
		flips <= flips + int'(drive.invert !== inv_q);
		if (clr) begin
			armed <= 1'b0;
		end else if (com_q != 4'h0 && drive.com_active != 4'h0 && drive.com_active !== com_q) begin
			if (armed && (flips + int'(drive.invert !== inv_q) != 2 || drive.invert !== 1'b0))
				bad <= bad + 1;
			armed <= 1'b1;
			flips <= 0;
		end
	end
endmodule // lsfc_glass

/* tb/lsfc_sva.sv */
// Port-level assertions for the segment display frame controller
module lsfc_sva
	import lsfc_pkg::*;
(
	// Clock, reset, bus
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_WR,
	input wire logic [7:0] SFR_WDATA,
	input wire logic [7:0] SFR_RDATA,
	// Display side
	input wire logic DCLK_IN,
	input wire lsfc_drive_t DRIVE,
	input wire logic PUMP_ENABLE,
	input wire logic LADDER_SELECT,
	input wire logic [5:0] BIAS_LEVEL
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	////////////////////////////////////////
	property p_pump; PUMP_ENABLE == (!LADDER_SELECT && DRIVE.display_on); endproperty
	a_pump: assert property (p_pump) else $error("pump enable wrong");
	property p_ladder;
		SFR_WR && SFR_ADDR == ADDR_VOLT_CFG |=> LADDER_SELECT == $past(SFR_WDATA[6]);
	endproperty
	a_ladder: assert property (p_ladder) else $error("ladder select wrong");
	property p_bias;
		SFR_WR && SFR_ADDR == ADDR_VOLT_CFG |=> BIAS_LEVEL == $past(SFR_WDATA[5:0]);
	endproperty
	a_bias: assert property (p_bias) else $error("bias level wrong");
	property p_com; DRIVE.display_on |-> $onehot(DRIVE.com_active); endproperty
	a_com: assert property (p_com) else $error("common not one-hot");
	property p_dark; !DRIVE.display_on |-> DRIVE.com_active == 4'h0 && DRIVE.seg_on == '0; endproperty
	a_dark: assert property (p_dark) else $error("dark display drives");
	property p_dat;
		SFR_WR && SFR_ADDR == ADDR_SEG_DAT ##1 !SFR_WR && SFR_ADDR == ADDR_SEG_DAT
			|-> SFR_RDATA == $past(SFR_WDATA);
	endproperty
	a_dat: assert property (p_dat) else $error("data register lost");
	property p_ptr;
		SFR_WR && SFR_ADDR == ADDR_SEG_PTR ##1 !SFR_WR && SFR_ADDR == ADDR_SEG_PTR
			|-> SFR_RDATA == ($past(SFR_WDATA) & PTR_WRITABLE_MASK);
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer readback wrong");
	property p_clear;
		SFR_WR && SFR_ADDR == ADDR_DISP_CFG && SFR_WDATA[6] ##1 !SFR_WR && SFR_ADDR == ADDR_DISP_CFG
			|-> !SFR_RDATA[6];
	endproperty
	a_clear: assert property (p_clear) else $error("clear bit stuck");
	property p_invert; (!SFR_WR && $stable(DCLK_IN))[*6] |=> $stable(DRIVE.invert); endproperty
	a_invert: assert property (p_invert) else $error("inversion without tick");
	c_rot: cover property (DRIVE.display_on && $changed(DRIVE.com_active));
	c_ptrw: cover property (SFR_WR && SFR_ADDR == ADDR_SEG_PTR && SFR_WDATA[7]);
	c_off: cover property ($fell(DRIVE.display_on));
endmodule // lsfc_sva

bind lsfc_top lsfc_sva lsfc_sva_inst (.CLK(CLK), .RST_B(RST_B), .SFR_ADDR(SFR_ADDR),
	.SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .DCLK_IN(DCLK_IN),
	.DRIVE(DRIVE), .PUMP_ENABLE(PUMP_ENABLE), .LADDER_SELECT(LADDER_SELECT),
	.BIAS_LEVEL(BIAS_LEVEL));

/* tb/tb_top.sv */
// Self-checking bench for the segment display frame controller
module tb_top
	import lsfc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK = 1'b0, RST_B = 1'b0, wr = 1'b0, dclk = 1'b0, rtc = 1'b0, dpsm = 1'b0, clr = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic [7:0] mem [15];
	logic [7:0] regs [7] = '{ADDR_DISP_CFG, ADDR_CLK_DIV, ADDR_VOLT_CFG, ADDR_SEG_PTR,
		ADDR_SEG_DAT, ADDR_UPD_CTL, 8'h97};
	lsfc_drive_t drive;
	logic pump, ladder, bias_half;
	logic [5:0] bias;
	logic [3:0] seen;
	bit dclk_run = 1'b0;
	int bad, failures = 0, n_tests = 0;
	always #25 CLK = ~CLK;
	// Fast display clock keeps frames short; the pin is synchronised anyway
	always #400 if (dclk_run) dclk = ~dclk;
	lsfc_top lsfc_top_inst (.CLK(CLK), .RST_B(RST_B), .SFR_ADDR(addr), .SFR_WR(wr),
		.SFR_WDATA(wdata), .SFR_RDATA(rdata), .DCLK_IN(dclk), .RTC_ENABLE(rtc),
		.DEEP_POWER_SAVING_MODE(dpsm), .DRIVE(drive), .PUMP_ENABLE(pump),
		.LADDER_SELECT(ladder), .BIAS_HALF(bias_half), .BIAS_LEVEL(bias));
	lsfc_glass lsfc_glass_inst (.clk(CLK), .clr(clr), .drive(drive), .seen(seen), .bad(bad));
	////////////////////////////////////////
	task check(input logic [33:0] got, input logic [33:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Strobe stays high across back-to-back writes
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge CLK);
	endtask
	task rd_reg(input logic [7:0] a, input logic [7:0] exp);
		wr = 1'b0;
		addr = a;
		#10;
		check(rdata, exp);
		@(negedge CLK);
	endtask
	task idle(input int n);
		wr = 1'b0;
		repeat (n) @(negedge CLK);
	endtask
	task get(input logic [7:0] a, input logic [7:0] exp);
		wr_reg(ADDR_SEG_PTR, a);
		rd_reg(ADDR_SEG_DAT, exp);
	endtask
	function automatic logic [28:0] exp_seg();
		logic [28:0] s = '0;
		for (int n = 0; n < 15; n++) begin
			s[2*n] = mem[n][0];
			if (n < 14) s[2*n+1] = mem[n][4];
		end
		return s;
	endfunction
	task conclude;
		$display("Checks %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		#2_000_000;
		failures++;
		conclude();
	end
	initial begin
		repeat (2) @(negedge CLK);
		RST_B = 1'b1;
		foreach (regs[i]) rd_reg(regs[i], 8'h00);
		wr_reg(ADDR_SEG_DAT, 8'h5A);
		rd_reg(ADDR_SEG_DAT, 8'h5A);
		for (int a = 0; a < 15; a++) begin
			mem[a] = 8'(8'h11 * (a + 1));
			wr_reg(ADDR_SEG_DAT, mem[a]);
			wr_reg(ADDR_SEG_PTR, 8'h80 | 8'(a));
		end
		for (int a = 0; a < 15; a++) get(8'(a), mem[a]);
		wr_reg(ADDR_SEG_DAT, 8'hFF);
		wr_reg(ADDR_SEG_PTR, 8'h8F);
		get(8'h0F, 8'h00);
		get(8'h0E, mem[14]);
		wr_reg(ADDR_SEG_PTR, 8'h43);
		rd_reg(ADDR_SEG_PTR, 8'h03);
		wr_reg(ADDR_DISP_CFG, 8'h80);
		idle(1);
		check(drive.com_active, 4'h1);
		check(drive.seg_on, exp_seg());
		// Frozen glass keeps the old byte while the working copy changes
		wr_reg(ADDR_UPD_CTL, 8'h01);
		wr_reg(ADDR_SEG_DAT, 8'h00);
		wr_reg(ADDR_SEG_PTR, 8'h80);
		idle(1);
		check(drive.seg_on, exp_seg());
		get(8'h00, 8'h00);
		wr_reg(ADDR_UPD_CTL, 8'h00);
		mem[0] = 8'h00;
		idle(1);
		check(drive.seg_on, exp_seg());
		wr_reg(ADDR_VOLT_CFG, 8'h2E);
		idle(1);
		check({ladder, bias, pump}, {1'b0, 6'h2E, 1'b1});
		wr_reg(ADDR_VOLT_CFG, 8'h40);
		idle(1);
		check({ladder, pump}, 2'b10);
		wr_reg(ADDR_VOLT_CFG, 8'h00);
		wr_reg(ADDR_DISP_CFG, 8'h04);
		idle(1);
		check({pump, bias_half}, 2'b01);
		wr_reg(ADDR_DISP_CFG, 8'hA0);
		for (int m = 0; m < 3; m++) begin
			wr_reg(ADDR_CLK_DIV, 8'(m << 6));
			idle(1);
			check(drive.display_on, m != 0);
		end
		// Automatic blink with the real time clock: first off phase after 512 ticks
		rtc = 1'b1;
		dclk_run = 1'b1;
		repeat (8000) @(negedge CLK);
		check(drive.display_on, 1'b1);
		repeat (400) @(negedge CLK);
		check(drive.display_on, 1'b0);
		dclk_run = 1'b0;
		rtc = 1'b0;
		wr_reg(ADDR_CLK_DIV, 8'h00);
		wr_reg(ADDR_DISP_CFG, 8'h90);
		dpsm = 1'b1;
		idle(1);
		check(drive.display_on, 1'b0);
		get(8'h05, mem[5]);
		dpsm = 1'b0;
		// Third pass: slow clock must cap the divider, else four commons never all show
		for (int k = 0; k < 3; k++) begin
			wr_reg(ADDR_CLK_DIV, (k == 2) ? 8'h0F : 8'h00);
			wr_reg(ADDR_DISP_CFG, (k == 1) ? 8'h82 : ((k == 2) ? 8'h8B : 8'h83));
			clr = 1'b1;
			// Mux change may reset the common; let that pass under clr
			idle(2);
			clr = 1'b0;
			dclk_run = 1'b1;
			repeat ((k == 2) ? 7000 : 640) @(negedge CLK);
			dclk_run = 1'b0;
			check(seen, (k == 1) ? 4'h7 : 4'hF);
			check(34'(bad), 34'h0);
		end
		wr_reg(ADDR_DISP_CFG, 8'h40);
		rd_reg(ADDR_DISP_CFG, 8'h00);
		get(8'h03, 8'h00);
		idle(2);
		conclude();
	end
endmodule // tb_top
